// File: common/jts_pkg.sv
// Constants, state codes and carrier types for the debug test access port.
// Assumes one core clock; the probe qualifies it with a test clock enable.
// Operation
// - Sample inputs only on enabled clock edges.
// - Shift selected register once per enabled cycle.
// - Chain 1: data 0..31, breakpoint cell exits first.
// - Chain 2 reaches debug unit registers.
// - No chain 0; only chains 1, 2 real.
// - Test reset is asynchronous, needs no clock.
// - Reset gives system mode and identification instruction.
// - Codes 0010 select, 1100 intest, 1110 identify.
// - 1111 and unassigned codes bypass; 0100 resumes.
// - Chain select captures constant 1000.
// - Chain connected at update, held until reselected.
// - Chain select register is four bits.
// - Chain 0 selected after test reset.
// - Intest: test mode, capture, shift chain.
// - Identify: capture code, shift, update ignored.
// - 32-bit identification with version, part, maker, one.
// - Identification from fixed inputs, no parallel output.
// - Bypass: one bit, captures zero, one-cycle delay.
// - Resume bypasses, exits debug at run-test/idle.
// - Instruction captures 0001, shifts lsb first.
// - Reserved chains shift out zeros.
package jts_pkg;

  localparam int IR_W = 4;
  localparam int SEL_W = 4;
  localparam int ID_W = 32;
  localparam int DATA_W = 32;
  localparam int CH1_W = DATA_W + 1;

  localparam logic [3:0] INSTR_CHAIN_SELECT = 4'h2;
  localparam logic [3:0] INSTR_INTEST = 4'hc;
  localparam logic [3:0] INSTR_IDCODE = 4'he;
  localparam logic [3:0] INSTR_BYPASS = 4'hf;
  localparam logic [3:0] INSTR_RESUME = 4'h4;

  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [3:0] SEL_CAPTURE_VALUE = 4'h8;
  localparam logic [3:0] CHAIN_RESET = 4'h0;
  localparam logic [3:0] CHAIN_CORE = 4'h1;
  localparam logic [3:0] CHAIN_DEBUG = 4'h2;

  localparam int ID_VERSION_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MANUF_LSB = 1;
  localparam logic ID_FIXED_BIT = 1'h1;
  localparam logic BYPASS_CAPTURE_VALUE = 1'h0;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jts_state_type;

  typedef struct packed {
    logic [3:0] version;
    logic [15:0] part_number;
    logic [10:0] manufacturer;
  } jts_id_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic breakpoint_request;
  } jts_core_type;

endpackage

// File: hw/jts_tap.sv
// Test access port controller, instruction decode and scan chains 1 and 2.
// Assumes the probe inputs are synchronous to CLK_I and qualified by the enable.
`timescale 1ns/1ps

module jts_tap
#(
  parameter int CH2_W = 38
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic TEST_RESET_N_I,
  input wire logic TEST_CLOCK_ENABLE_I,
  input wire logic TEST_MODE_SELECT_IN_I,
  input wire logic SERIAL_TEST_IN_I,
  output logic SERIAL_TEST_OUT_O,
  output logic SERIAL_TEST_OUT_EN_O,
  input wire jts_pkg::jts_id_type ID_I,
  input wire jts_pkg::jts_core_type CORE_I,
  output jts_pkg::jts_core_type CORE_O,
  output logic CORE_TEST_MODE_O,
  input wire logic [CH2_W-1:0] DEBUG_REG_I,
  output logic [CH2_W-1:0] DEBUG_REG_O,
  output logic DEBUG_REG_UPDATE_O,
  output logic DEBUG_EXIT_O,
  output logic [3:0] ACTIVE_CHAIN_O
);

  // ==========================================================
  // Declarations
  logic tck;
  logic tms;
  jts_pkg::jts_state_type state_q;
  jts_pkg::jts_state_type state_d;
  logic [3:0] ir_sh_q;
  logic [3:0] ir_q;
  logic [3:0] sel_q;
  logic [3:0] chain_q;
  logic bp_q;
  logic [jts_pkg::ID_W-1:0] id_q;
  logic [jts_pkg::CH1_W-1:0] c1_q;
  logic [CH2_W-1:0] c2_q;
  logic [jts_pkg::DATA_W-1:0] data_rev;
  jts_pkg::jts_core_type core_q;
  logic [CH2_W-1:0] dbg_q;
  logic dbg_upd_q;
  logic exit_q;
  logic [3:0] instr_next;
  logic is_intest;
  logic is_id;
  logic is_sel;
  logic is_byp;
  logic on_c1;
  logic on_c2;
  logic dr_out;

  assign tck = TEST_CLOCK_ENABLE_I;
  assign tms = TEST_MODE_SELECT_IN_I;

  // ==========================================================
  // Controller state machine
  always_comb
  begin
    case (state_q)
      jts_pkg::ST_RESET: state_d = tms ? jts_pkg::ST_RESET : jts_pkg::ST_IDLE;
      jts_pkg::ST_IDLE: state_d = tms ? jts_pkg::ST_SEL_DR : jts_pkg::ST_IDLE;
      jts_pkg::ST_SEL_DR: state_d = tms ? jts_pkg::ST_SEL_IR : jts_pkg::ST_CAP_DR;
      jts_pkg::ST_CAP_DR: state_d = tms ? jts_pkg::ST_EXIT1_DR : jts_pkg::ST_SHIFT_DR;
      jts_pkg::ST_SHIFT_DR: state_d = tms ? jts_pkg::ST_EXIT1_DR : jts_pkg::ST_SHIFT_DR;
      jts_pkg::ST_EXIT1_DR: state_d = tms ? jts_pkg::ST_UPD_DR : jts_pkg::ST_PAUSE_DR;
      jts_pkg::ST_PAUSE_DR: state_d = tms ? jts_pkg::ST_EXIT2_DR : jts_pkg::ST_PAUSE_DR;
      jts_pkg::ST_EXIT2_DR: state_d = tms ? jts_pkg::ST_UPD_DR : jts_pkg::ST_SHIFT_DR;
      jts_pkg::ST_UPD_DR: state_d = tms ? jts_pkg::ST_SEL_DR : jts_pkg::ST_IDLE;
      jts_pkg::ST_SEL_IR: state_d = tms ? jts_pkg::ST_RESET : jts_pkg::ST_CAP_IR;
      jts_pkg::ST_CAP_IR: state_d = tms ? jts_pkg::ST_EXIT1_IR : jts_pkg::ST_SHIFT_IR;
      jts_pkg::ST_SHIFT_IR: state_d = tms ? jts_pkg::ST_EXIT1_IR : jts_pkg::ST_SHIFT_IR;
      jts_pkg::ST_EXIT1_IR: state_d = tms ? jts_pkg::ST_UPD_IR : jts_pkg::ST_PAUSE_IR;
      jts_pkg::ST_PAUSE_IR: state_d = tms ? jts_pkg::ST_EXIT2_IR : jts_pkg::ST_PAUSE_IR;
      jts_pkg::ST_EXIT2_IR: state_d = tms ? jts_pkg::ST_UPD_IR : jts_pkg::ST_SHIFT_IR;
      jts_pkg::ST_UPD_IR: state_d = tms ? jts_pkg::ST_SEL_DR : jts_pkg::ST_IDLE;
      default: state_d = jts_pkg::ST_RESET;
    endcase
  end

  // Test reset acts without clock so a dead probe clock cannot block it
  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
      state_q <= jts_pkg::ST_RESET;
    else if (RST_I)
      state_q <= jts_pkg::ST_RESET;
    else if (tck)
      state_q <= state_d;
  end

  // ==========================================================
  // Instruction register
  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
    begin
      ir_sh_q <= jts_pkg::IR_CAPTURE_VALUE;
      ir_q <= jts_pkg::INSTR_IDCODE;
    end
    else if (RST_I)
    begin
      ir_sh_q <= jts_pkg::IR_CAPTURE_VALUE;
      ir_q <= jts_pkg::INSTR_IDCODE;
    end
    else if (tck)
    begin
      if (state_q == jts_pkg::ST_CAP_IR)
        ir_sh_q <= jts_pkg::IR_CAPTURE_VALUE;
      else if (state_q == jts_pkg::ST_SHIFT_IR)
        ir_sh_q <= {SERIAL_TEST_IN_I, ir_sh_q[3:1]};
      if (state_q == jts_pkg::ST_RESET)
        ir_q <= jts_pkg::INSTR_IDCODE;
      else if (state_q == jts_pkg::ST_UPD_IR)
        ir_q <= ir_sh_q;
    end
  end

  // Unassigned codes and resume fall through to bypass
  assign is_sel = (ir_q == jts_pkg::INSTR_CHAIN_SELECT);
  assign is_intest = (ir_q == jts_pkg::INSTR_INTEST);
  assign is_id = (ir_q == jts_pkg::INSTR_IDCODE);
  assign is_byp = !(is_sel || is_intest || is_id);
  assign on_c1 = is_intest && (chain_q == jts_pkg::CHAIN_CORE);
  assign on_c2 = is_intest && (chain_q == jts_pkg::CHAIN_DEBUG);

  // ==========================================================
  // Scan path select register and active chain
  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
    begin
      sel_q <= jts_pkg::SEL_CAPTURE_VALUE;
      chain_q <= jts_pkg::CHAIN_RESET;
    end
    else if (RST_I)
    begin
      sel_q <= jts_pkg::SEL_CAPTURE_VALUE;
      chain_q <= jts_pkg::CHAIN_RESET;
    end
    else if (tck && is_sel)
    begin
      if (state_q == jts_pkg::ST_CAP_DR)
        sel_q <= jts_pkg::SEL_CAPTURE_VALUE;
      else if (state_q == jts_pkg::ST_SHIFT_DR)
        sel_q <= {SERIAL_TEST_IN_I, sel_q[3:1]};
      else if (state_q == jts_pkg::ST_UPD_DR)
        chain_q <= sel_q;
    end
  end

  // ==========================================================
  // Bypass and identification registers
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      bp_q <= jts_pkg::BYPASS_CAPTURE_VALUE;
    else if (tck && is_byp && state_q == jts_pkg::ST_CAP_DR)
      bp_q <= jts_pkg::BYPASS_CAPTURE_VALUE;
    else if (tck && is_byp && state_q == jts_pkg::ST_SHIFT_DR)
      bp_q <= SERIAL_TEST_IN_I;
  end

  // No parallel output: the code is only ever shifted out
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      id_q <= '0;
    else if (tck && is_id && state_q == jts_pkg::ST_CAP_DR)
      id_q <= {ID_I, jts_pkg::ID_FIXED_BIT};
    else if (tck && is_id && state_q == jts_pkg::ST_SHIFT_DR)
      id_q <= {SERIAL_TEST_IN_I, id_q[jts_pkg::ID_W-1:1]};
  end

  // ==========================================================
  // Scan chain 1: data bit 0 sits next to the serial input
  for (genvar i = 0; i < jts_pkg::DATA_W; i++)
  begin : g_rev
    assign data_rev[i] = CORE_I.data[jts_pkg::DATA_W-1-i];
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      c1_q <= '0;
    else if (tck && on_c1 && state_q == jts_pkg::ST_CAP_DR)
      c1_q <= {data_rev, CORE_I.breakpoint_request};
    else if (tck && on_c1 && state_q == jts_pkg::ST_SHIFT_DR)
      c1_q <= {SERIAL_TEST_IN_I, c1_q[jts_pkg::CH1_W-1:1]};
  end

  // Cells drive core and system only while intest is current
  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
      core_q <= '0;
    else if (RST_I)
      core_q <= '0;
    else if (tck && on_c1 && state_q == jts_pkg::ST_UPD_DR)
    begin
      core_q.breakpoint_request <= c1_q[0];
      for (int k = 0; k < jts_pkg::DATA_W; k++)
        core_q.data[k] <= c1_q[jts_pkg::CH1_W-1-k];
    end
  end

  assign CORE_TEST_MODE_O = is_intest;
  assign CORE_O = is_intest ? core_q : CORE_I;

  // ==========================================================
  // Scan chain 2: debug unit register access
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      c2_q <= '0;
    else if (tck && on_c2 && state_q == jts_pkg::ST_CAP_DR)
      c2_q <= DEBUG_REG_I;
    else if (tck && on_c2 && state_q == jts_pkg::ST_SHIFT_DR)
      c2_q <= {SERIAL_TEST_IN_I, c2_q[CH2_W-1:1]};
  end

  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
    begin
      dbg_q <= '0;
      dbg_upd_q <= 1'h0;
    end
    else if (RST_I)
    begin
      dbg_q <= '0;
      dbg_upd_q <= 1'h0;
    end
    else
    begin
      dbg_upd_q <= tck && on_c2 && state_q == jts_pkg::ST_UPD_DR;
      if (tck && on_c2 && state_q == jts_pkg::ST_UPD_DR)
        dbg_q <= c2_q;
    end
  end

  assign DEBUG_REG_O = dbg_q;
  assign DEBUG_REG_UPDATE_O = dbg_upd_q;

  // ==========================================================
  // Resume: one pulse on entry to run-test/idle
  // Idle straight after update-IR must see the code loaded on that edge
  assign instr_next = (state_q == jts_pkg::ST_RESET) ? jts_pkg::INSTR_IDCODE
    : (state_q == jts_pkg::ST_UPD_IR) ? ir_sh_q : ir_q;
  always_ff @(posedge CLK_I or negedge TEST_RESET_N_I)
  begin
    if (!TEST_RESET_N_I)
      exit_q <= 1'h0;
    else if (RST_I)
      exit_q <= 1'h0;
    else
      exit_q <= tck && (instr_next == jts_pkg::INSTR_RESUME) && (state_q != jts_pkg::ST_IDLE)
        && (state_d == jts_pkg::ST_IDLE);
  end

  assign DEBUG_EXIT_O = exit_q;
  assign ACTIVE_CHAIN_O = chain_q;

  // ==========================================================
  // Serial output mux; reserved chains read zero
  always_comb
  begin
    if (is_sel)
      dr_out = sel_q[0];
    else if (is_id)
      dr_out = id_q[0];
    else if (on_c1)
      dr_out = c1_q[0];
    else if (on_c2)
      dr_out = c2_q[0];
    else if (is_intest)
      dr_out = 1'h0;
    else
      dr_out = bp_q;
  end

  assign SERIAL_TEST_OUT_O = (state_q == jts_pkg::ST_SHIFT_IR) ? ir_sh_q[0] : dr_out;
  assign SERIAL_TEST_OUT_EN_O = (state_q == jts_pkg::ST_SHIFT_IR)
    || (state_q == jts_pkg::ST_SHIFT_DR);

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I || !TEST_RESET_N_I);

  AST_FREEZE_NO_EN: assert property (!tck |=> $stable(state_q) && $stable(ir_sh_q) && $stable(bp_q))
    else $error("state moved without clock enable");
  AST_IR_CAPTURE: assert property (tck && state_q == jts_pkg::ST_CAP_IR |=> ir_sh_q == 4'h1)
    else $error("instruction capture value wrong");
  AST_SEL_CAPTURE: assert property (tck && is_sel && state_q == jts_pkg::ST_CAP_DR
    |=> sel_q == 4'h8 && SERIAL_TEST_OUT_O == 1'h0)
    else $error("chain select capture value wrong");
  AST_CHAIN_HOLD: assert property (!(tck && is_sel && state_q == jts_pkg::ST_UPD_DR)
    |=> $stable(chain_q))
    else $error("active chain changed without update");
  AST_BYPASS_DELAY: assert property (tck && is_byp && state_q == jts_pkg::ST_SHIFT_DR
    |=> bp_q == $past(SERIAL_TEST_IN_I))
    else $error("bypass delay not one cycle");
  AST_UNASSIGNED_BYPASS: assert property (state_q == jts_pkg::ST_SHIFT_DR
    && !(is_sel || is_intest || is_id) |-> SERIAL_TEST_OUT_O == bp_q)
    else $error("unassigned code not bypass");
  AST_ID_CAPTURE: assert property (tck && is_id && state_q == jts_pkg::ST_CAP_DR
    |=> id_q[0] == 1'h1 && id_q[31:28] == $past(ID_I.version))
    else $error("identification capture wrong");
  AST_RESERVED_ZERO: assert property (state_q == jts_pkg::ST_SHIFT_DR && is_intest
    && chain_q != 4'h1 && chain_q != 4'h2 |-> SERIAL_TEST_OUT_O == 1'h0)
    else $error("reserved chain not zero");
  AST_CH1_SHIFT: assert property (tck && on_c1 && state_q == jts_pkg::ST_SHIFT_DR
    |=> c1_q[32] == $past(SERIAL_TEST_IN_I) && c1_q[0] == $past(c1_q[1]))
    else $error("chain 1 shift wrong");
  AST_RESUME_EXIT: assert property (tck && ir_q == 4'h4 && state_q == jts_pkg::ST_UPD_DR
    && !tms |=> DEBUG_EXIT_O ##1 !DEBUG_EXIT_O)
    else $error("resume pulse wrong");
  AST_RESET_IDCODE: assert property (tck && state_q == jts_pkg::ST_RESET
    |=> ir_q == 4'he)
    else $error("reset state not identification");

  COV_BYPASS: cover property (tck && is_byp && state_q == jts_pkg::ST_SHIFT_DR);
  COV_SELECT_CORE: cover property (tck && is_sel && state_q == jts_pkg::ST_UPD_DR && sel_q == 4'h1);
  COV_DEBUG_UPDATE: cover property (DEBUG_REG_UPDATE_O);
  COV_RESUME: cover property (DEBUG_EXIT_O);

endmodule

// File: testbench/jts_probe.sv
// Debug probe model: drives mode select, serial in, clock enable and test reset.
// Assumes callers enter each task just after a rising edge of clk_i.
`timescale 1ns/1ps

module jts_probe
(
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tms_o,
  output logic tdi_o,
  output logic en_o,
  output logic trst_n_o
);
  initial
  begin
    tms_o = 1'h1;
    tdi_o = 1'h0;
    en_o = 1'h0;
    trst_n_o = 1'h1;
  end

  // ====================================
  // Single enabled cycle
  // ====================================
  // Serial out is read before the edge that shifts it away
  task automatic step(input logic m, input logic d, output logic q);
  begin
    tms_o <= m;
    tdi_o <= d;
    en_o <= 1'h1;
    @(negedge clk_i);
    q = tdo_i;
    @(posedge clk_i);
  end
  endtask

  // Serial in is junk outside shifts, so it toggles rather than holding a value
  task automatic move(input logic m);
    logic q;
  begin
    step(m, ~tdi_o, q);
  end
  endtask

  // Enable stays low between frames; mode select may wiggle meanwhile
  task automatic idle(input int n, input logic m);
  begin
    en_o <= 1'h0;
    tms_o <= m;
    repeat (n) @(posedge clk_i);
  end
  endtask

  // ====================================
  // Scans and resets
  // ====================================
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
  begin
    dout = 64'h0;
    move(1'h1);
    if (ir)
      move(1'h1);
    move(1'h0);
    move(1'h0);
    for (int k = 0; k < n; k++)
    begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    move(1'h1);
    move(1'h0);
    idle(2, 1'h0);
  end
  endtask

  task automatic tap_reset();
  begin
    repeat (5) move(1'h1);
    move(1'h0);
    idle(1, 1'h0);
  end
  endtask

  // Reset pulse needs no enabled clock
  task automatic trst(input logic v);
  begin
    trst_n_o <= v;
    en_o <= 1'h0;
    repeat (2) @(posedge clk_i);
  end
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the test access port, probe model on the serial side.
// Assumes a 100 MHz core clock; all scans are fixed-length, so no open waits.
`timescale 1ns/1ps

module tb;
  localparam int CH2 = 38;
  logic clk;
  logic rst = 1'h1;
  logic tms;
  logic tdi;
  logic en;
  logic trst_n;
  logic tdo;
  logic tdo_en;
  logic core_tm;
  logic dbg_upd;
  logic dbg_exit;
  logic [3:0] chain;
  // Identity fields are arbitrary values
  jts_pkg::jts_id_type id_v = {4'h3, 16'h5a5a, 11'h2c3};
  jts_pkg::jts_core_type core_in = {32'hc3a5_0f96, 1'h1};
  jts_pkg::jts_core_type core_out;
  logic [CH2-1:0] dbg_in = 38'h2a_5c3e_91b7;
  logic [CH2-1:0] dbg_out;
  logic [63:0] got;
  logic [63:0] idv;
  int fail_count = 0;
  int samples_checked = 0;
  int exit_seen = 0;
  int upd_seen = 0;
  int oe_seen = 0;

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  jts_probe jts_probe_i (.clk_i(clk), .tdo_i(tdo), .tms_o(tms), .tdi_o(tdi), .en_o(en),
    .trst_n_o(trst_n));

  jts_tap #(.CH2_W(CH2)) jts_tap_i (.CLK_I(clk), .RST_I(rst), .TEST_RESET_N_I(trst_n),
    .TEST_CLOCK_ENABLE_I(en), .TEST_MODE_SELECT_IN_I(tms), .SERIAL_TEST_IN_I(tdi),
    .SERIAL_TEST_OUT_O(tdo), .SERIAL_TEST_OUT_EN_O(tdo_en), .ID_I(id_v), .CORE_I(core_in),
    .CORE_O(core_out), .CORE_TEST_MODE_O(core_tm), .DEBUG_REG_I(dbg_in),
    .DEBUG_REG_O(dbg_out), .DEBUG_REG_UPDATE_O(dbg_upd), .DEBUG_EXIT_O(dbg_exit),
    .ACTIVE_CHAIN_O(chain));

  always @(posedge clk)
  begin
    if (dbg_exit === 1'h1)
      exit_seen++;
    if (dbg_upd === 1'h1)
      upd_seen++;
    if (tdo_en === 1'h1)
      oe_seen++;
  end

  // ====================================
  // Helpers
  // ====================================
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // Chain 1 cell k (0 nearest serial out) against the core struct; own inverse
  function automatic logic [32:0] swap1(input logic [32:0] x);
    logic [32:0] r;
  begin
    r[0] = x[0];
    for (int k = 1; k < 33; k++)
      r[k] = x[33-k];
    return r;
  end
  endfunction

  task automatic ir(input logic [3:0] code);
  begin
    jts_probe_i.scan(1'h1, 4, 64'(code), got);
  end
  endtask

  task automatic sel(input logic [3:0] ch);
  begin
    ir(jts_pkg::INSTR_CHAIN_SELECT);
    jts_probe_i.scan(1'h0, 4, 64'(ch), got);
    chk("select capture", 64'(jts_pkg::SEL_CAPTURE_VALUE), 64'(got[3:0]));
    chk("active chain", 64'(ch), 64'(chain));
    ir(jts_pkg::INSTR_INTEST);
    chk("test mode", 64'h1, 64'(core_tm));
  end
  endtask

  // ====================================
  // Scenarios
  // ====================================
  task automatic t_reset();
  begin
    jts_probe_i.trst(1'h0);
    chk("reset chain", 64'h0, 64'(chain));
    chk("reset mode", 64'h0, 64'(core_tm));
    chk("reset core", 64'(core_in), 64'(core_out));
    jts_probe_i.trst(1'h1);
    jts_probe_i.move(1'h0);
    jts_probe_i.scan(1'h0, 32, 64'h0, got);
    chk("id", idv, got);
    $display("test reset done");
  end
  endtask

  task automatic t_instr();
    logic [3:0] codes [4];
    int e0;
  begin
    codes = '{jts_pkg::INSTR_BYPASS, 4'h7, 4'h0, jts_pkg::INSTR_RESUME};
    foreach (codes[i])
    begin
      e0 = exit_seen;
      jts_probe_i.scan(1'h1, 4, 64'(codes[i]), got);
      chk("ir capture", 64'(jts_pkg::IR_CAPTURE_VALUE), 64'(got[3:0]));
      jts_probe_i.scan(1'h0, 2, 64'h3, got);
      chk("bypass", 64'h2, 64'(got[1:0]));
      chk("exit", (codes[i] == jts_pkg::INSTR_RESUME) ? 64'h2 : 64'h0,
        64'(exit_seen - e0));
    end
    // Mode select high for six disabled cycles must not reset the controller
    jts_probe_i.idle(6, 1'h1);
    jts_probe_i.scan(1'h0, 1, 64'h1, got);
    chk("disabled edges", 64'h0, got);
    jts_probe_i.tap_reset();
    jts_probe_i.scan(1'h0, 32, 64'h0, got);
    chk("mode reset id", idv, got);
    $display("instruction test done");
  end
  endtask

  task automatic t_chain1();
    logic [63:0] din;
  begin
    din = 64'h1_6e2d_b4c5;
    sel(4'h1);
    jts_probe_i.scan(1'h0, 33, din, got);
    chk("chain1 out", 64'(swap1(core_in)), got);
    chk("chain1 update", 64'(swap1(din[32:0])), 64'(core_out));
    ir(jts_pkg::INSTR_IDCODE);
    jts_probe_i.scan(1'h0, 32, 64'h0, got);
    chk("id again", idv, got);
    chk("chain held", 64'h1, 64'(chain));
    chk("system mode", 64'(core_in), 64'(core_out));
    $display("chain 1 test done");
  end
  endtask

  task automatic t_chain2();
    logic [63:0] din;
    int u0;
    int o0;
  begin
    din = 64'h15_a3c1_6e4d;
    sel(4'h2);
    u0 = upd_seen;
    o0 = oe_seen;
    jts_probe_i.scan(1'h0, CH2, din, got);
    chk("chain2 out", 64'(dbg_in), got);
    chk("chain2 update", 64'(din[CH2-1:0]), 64'(dbg_out));
    chk("chain2 pulse", 64'h1, 64'(upd_seen - u0));
    chk("out enable cycles", 64'(CH2), 64'(oe_seen - o0));
    chk("out enable idle", 64'h0, 64'(tdo_en));
    $display("chain 2 test done");
  end
  endtask

  task automatic t_reserved();
  begin
    sel(4'h0);
    jts_probe_i.scan(1'h0, 8, 64'hff, got);
    chk("chain0 zeros", 64'h0, got);
    sel(4'h5);
    jts_probe_i.scan(1'h0, 8, 64'hff, got);
    chk("chain5 zeros", 64'h0, got);
    $display("reserved chain test done");
  end
  endtask

  task automatic report_and_stop();
  begin
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // Guards against a hang anywhere in the sequence
  initial
  begin
    #500000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    idv = {32'h0, id_v, jts_pkg::ID_FIXED_BIT};
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_instr();
    t_chain1();
    t_chain2();
    t_reserved();
    t_reset();
    report_and_stop();
  end
endmodule
